// [shared/rcf_pkg.sv]
// constants, register map and field layout of the reset-cause flag block
//
// Contract
// - Bit 7 is set by hardware on a call-stack overflow, can be cleared by a firmware write, and stays clear until the next overflow;
//   the code also sets it when firmware writes 1 to it.
// - Bit 6 is set by hardware on a call-stack underflow and can be cleared by a firmware write.
// - Bits 5 and 4 are not implemented, always read as zero and ignore writes.
// - Bit 3 is active low, cleared by hardware on a reset-pin reset, and re-armed by firmware writing 1.
// - Bit 2 is active low, cleared by hardware when the reset instruction runs, and re-armed by firmware writing 1.
// - Bit 1 is active low, cleared by hardware on power-on, and firmware must write it back to 1 afterwards.
// - Bit 0 is active low, cleared by hardware on brown-out, and firmware must write it back to 1 after power-on or brown-out.
// - Power-on and brown-out load stack flags 0 and pin/instruction flags 1; other resets leave power-on and brown-out flags alone.
// - A stack overflow or underflow requests a device reset only while the stack reset enable is set, and its flag records the cause.
// - After power-on the register reads 00_110x, after brown-out 00_11u0 with the power-on flag unchanged.
package rcf_pkg;

  // =========================================================
  // register port geometry
  localparam int unsigned RCF_ADDR_W = 4;
  localparam int unsigned RCF_DATA_W = 8;

  // =========================================================
  // register offsets
  localparam logic [RCF_ADDR_W-1:0] RCF_OFF_FLAGS    = 4'h0;
  localparam logic [RCF_ADDR_W-1:0] RCF_OFF_IRQ_STAT = 4'h1;
  localparam logic [RCF_ADDR_W-1:0] RCF_OFF_IRQ_MASK = 4'h2;

  // =========================================================
  // flag bit positions (same layout in status and mask)
  localparam int unsigned RCF_BIT_OVF  = 7;
  localparam int unsigned RCF_BIT_UNF  = 6;
  localparam int unsigned RCF_BIT_PIN  = 3;
  localparam int unsigned RCF_BIT_SOFT = 2;
  localparam int unsigned RCF_BIT_POR  = 1;
  localparam int unsigned RCF_BIT_BOR  = 0;

  // =========================================================
  // field masks and load patterns
  localparam logic [RCF_DATA_W-1:0] RCF_IMPL_MASK = 8'hcf; // bits 5:4 absent
  localparam logic [RCF_DATA_W-1:0] RCF_HW_VAL    = 8'hc0; // value a hw event forces
  localparam logic [RCF_DATA_W-1:0] RCF_POR_VAL   = 8'h0c; // 00_1100, unknown bor taken as 0
  localparam logic [RCF_DATA_W-1:0] RCF_POR_LOAD  = 8'hcf;
  localparam logic [RCF_DATA_W-1:0] RCF_BOR_VAL   = 8'h0c; // 00_11u0
  localparam logic [RCF_DATA_W-1:0] RCF_BOR_LOAD  = 8'hcd; // power-on flag untouched
  localparam logic [RCF_DATA_W-1:0] RCF_RST_VAL   = 8'h0c; // logic reset acts as power-on
  localparam logic [RCF_DATA_W-1:0] RCF_MASK_RST  = 8'h00;
  localparam logic [RCF_DATA_W-1:0] RCF_ZERO      = 8'h00;

endpackage : rcf_pkg

// [hdl/rcf_flag_cell.sv]
// one reset-cause flag bit with power-up load, hardware event and firmware write
`timescale 1ns/1ps
module rcf_flag_cell #(
  parameter logic HW_VAL   = 1'b1,
  parameter logic INIT_VAL = 1'b0
) (
  input  wire logic i_sys_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_load,
  input  wire logic i_load_val,
  input  wire logic i_hw_evt,
  input  wire logic i_fw_wr,
  input  wire logic i_fw_val,
  output logic      o_flag
);
  import rcf_pkg::*;

  typedef struct packed {
    logic flag;
  } rcf_cell_state_t;

  rcf_cell_state_t state_q;
  rcf_cell_state_t state_d;

  // =========================================================
  // next value: power-up load, then hw event, then firmware
  always_comb begin
    state_d = state_q;
    if (i_load) begin
      state_d.flag = i_load_val;
    end else if (i_hw_evt) begin
      state_d.flag = HW_VAL;          // hw wins over a write
    end else if (i_fw_wr) begin
      state_d.flag = i_fw_val;
    end
  end

  // =========================================================
  // storage
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      state_q.flag <= INIT_VAL;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_flag = state_q.flag;

endmodule : rcf_flag_cell

// [hdl/rcf_irq_ctrl.sv]
// sticky event status, mask and level interrupt of the reset-cause block
`timescale 1ns/1ps
module rcf_irq_ctrl (
  input  wire logic                           i_sys_clk,
  input  wire logic                           i_sys_rst,
  input  wire logic [rcf_pkg::RCF_DATA_W-1:0] i_evt,
  input  wire logic                           i_stat_rd,
  input  wire logic                           i_mask_wr,
  input  wire logic [rcf_pkg::RCF_DATA_W-1:0] i_mask_val,
  output logic      [rcf_pkg::RCF_DATA_W-1:0] o_status,
  output logic      [rcf_pkg::RCF_DATA_W-1:0] o_mask,
  output logic                                o_irq
);
  import rcf_pkg::*;

  typedef struct packed {
    logic [RCF_DATA_W-1:0] status;
    logic [RCF_DATA_W-1:0] mask;
    logic                  irq;
  } rcf_irq_state_t;

  rcf_irq_state_t state_q;
  rcf_irq_state_t state_d;

  // =========================================================
  // read clears, but an event in the same cycle survives the clear
  always_comb begin
    state_d        = state_q;
    state_d.status = (i_stat_rd ? RCF_ZERO : state_q.status) | (i_evt & RCF_IMPL_MASK);
    if (i_mask_wr) begin
      state_d.mask = i_mask_val & RCF_IMPL_MASK;
    end
    // registered from next values so the level tracks status without lag
    state_d.irq = |(state_d.status & state_d.mask);
  end

  // =========================================================
  // storage
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      state_q.status <= RCF_ZERO;
      state_q.mask   <= RCF_MASK_RST;
      state_q.irq    <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_status = state_q.status;
  assign o_mask   = state_q.mask;
  assign o_irq    = state_q.irq;

endmodule : rcf_irq_ctrl

// [hdl/rcf_reset_cause.sv]
// reset-cause flag register with register port, stack reset request and interrupt
`timescale 1ns/1ps
module rcf_reset_cause (
  input  wire logic                           i_sys_clk,
  input  wire logic                           i_sys_rst,
  // register port
  input  wire logic [rcf_pkg::RCF_ADDR_W-1:0] i_addr,
  input  wire logic [rcf_pkg::RCF_DATA_W-1:0] i_wdata,
  input  wire logic                           i_wr,
  input  wire logic                           i_rd,
  output logic      [rcf_pkg::RCF_DATA_W-1:0] o_rdata,
  // reset event pulses from the surrounding core logic
  input  wire logic                           i_stack_overflow,
  input  wire logic                           i_stack_underflow,
  input  wire logic                           i_pin_reset,
  input  wire logic                           i_soft_reset,
  input  wire logic                           i_por_event,
  input  wire logic                           i_bor_event,
  input  wire logic                           i_stack_reset_enable,
  // results
  output logic      [rcf_pkg::RCF_DATA_W-1:0] o_reset_cause_flags,
  output logic                                o_stack_reset_req,
  output logic                                o_irq
);
  import rcf_pkg::*;

  // =========================================================
  // shared address decode
  function automatic logic addr_hit(input logic [RCF_ADDR_W-1:0] a,
                                    input logic [RCF_ADDR_W-1:0] off);
    addr_hit = (a == off);
  endfunction : addr_hit

  typedef struct packed {
    logic [RCF_DATA_W-1:0] rdata;
    logic                  stack_req;
  } rcf_top_state_t;

  rcf_top_state_t        state_q;
  rcf_top_state_t        state_d;
  logic [RCF_DATA_W-1:0] flags;
  logic [RCF_DATA_W-1:0] irq_status;
  logic [RCF_DATA_W-1:0] irq_mask;
  logic [RCF_DATA_W-1:0] hw_evt;
  logic [RCF_DATA_W-1:0] irq_evt;
  logic [RCF_DATA_W-1:0] load_en;
  logic [RCF_DATA_W-1:0] load_val;
  logic                  flags_wr;
  logic                  mask_wr;
  logic                  stat_rd;

  // =========================================================
  // write and read strobes per register
  assign flags_wr = i_wr && addr_hit(i_addr, RCF_OFF_FLAGS);
  assign mask_wr  = i_wr && addr_hit(i_addr, RCF_OFF_IRQ_MASK);
  assign stat_rd  = i_rd && addr_hit(i_addr, RCF_OFF_IRQ_STAT);

  // =========================================================
  // event vectors in flag layout
  always_comb begin
    hw_evt                = RCF_ZERO;
    hw_evt[RCF_BIT_OVF]   = i_stack_overflow;
    hw_evt[RCF_BIT_UNF]   = i_stack_underflow;
    hw_evt[RCF_BIT_PIN]   = i_pin_reset;
    hw_evt[RCF_BIT_SOFT]  = i_soft_reset;
    irq_evt               = hw_evt;
    irq_evt[RCF_BIT_POR]  = i_por_event;
    irq_evt[RCF_BIT_BOR]  = i_bor_event;
  end

  // =========================================================
  // power-up loads; power-on outranks brown-out when both arrive
  always_comb begin
    if (i_por_event) begin
      load_en  = RCF_POR_LOAD;
      load_val = RCF_POR_VAL;
    end else if (i_bor_event) begin
      load_en  = RCF_BOR_LOAD;                 // power-on flag kept
      load_val = RCF_BOR_VAL;
    end else begin
      load_en  = RCF_ZERO;
      load_val = RCF_ZERO;
    end
  end

  // =========================================================
  // one flag cell per implemented bit; absent bits are constant zero
  for (genvar gi = 0; gi < RCF_DATA_W; gi++) begin : g_flag
    if (RCF_IMPL_MASK[gi]) begin : g_cell
      rcf_flag_cell #(
        .HW_VAL   (RCF_HW_VAL[gi]),
        .INIT_VAL (RCF_RST_VAL[gi])
      ) u_cell (
        .i_sys_clk  (i_sys_clk),
        .i_sys_rst  (i_sys_rst),
        .i_load     (load_en[gi]),
        .i_load_val (load_val[gi]),
        .i_hw_evt   (hw_evt[gi]),
        .i_fw_wr    (flags_wr),
        .i_fw_val   (i_wdata[gi]),
        .o_flag     (flags[gi])
      );
    end else begin : g_absent
      assign flags[gi] = 1'b0;
    end
  end

  // =========================================================
  // interrupt status, mask and level output
  rcf_irq_ctrl u_irq (
    .i_sys_clk  (i_sys_clk),
    .i_sys_rst  (i_sys_rst),
    .i_evt      (irq_evt),
    .i_stat_rd  (stat_rd),
    .i_mask_wr  (mask_wr),
    .i_mask_val (i_wdata),
    .o_status   (irq_status),
    .o_mask     (irq_mask),
    .o_irq      (o_irq)
  );

  // =========================================================
  // read mux and stack reset request
  always_comb begin
    state_d           = state_q;
    // request only while enabled; the flag records the cause either way
    state_d.stack_req = (i_stack_overflow || i_stack_underflow) && i_stack_reset_enable;
    state_d.rdata     = RCF_ZERO;              // unmapped reads return zero
    if (i_rd) begin
      if (addr_hit(i_addr, RCF_OFF_FLAGS)) begin
        state_d.rdata = flags & RCF_IMPL_MASK;
      end else if (addr_hit(i_addr, RCF_OFF_IRQ_STAT)) begin
        state_d.rdata = irq_status;            // value before the clear
      end else if (addr_hit(i_addr, RCF_OFF_IRQ_MASK)) begin
        state_d.rdata = irq_mask;
      end
    end
  end

  // =========================================================
  // storage
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      state_q.rdata     <= RCF_ZERO;
      state_q.stack_req <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_rdata             = state_q.rdata;
  assign o_stack_reset_req   = state_q.stack_req;
  assign o_reset_cause_flags = flags;

  // =========================================================
  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  logic quiet;
  assign quiet = !i_por_event && !i_bor_event;

  ovf_set_a: assert property (
    (i_stack_overflow && quiet) |=> o_reset_cause_flags[RCF_BIT_OVF])
    else $error("overflow flag not set after stack overflow");

  ovf_stays_clear_a: assert property (
    (flags_wr && !i_wdata[RCF_BIT_OVF] && !i_stack_overflow && quiet)
      ##1 (!i_stack_overflow)[*3] |-> !o_reset_cause_flags[RCF_BIT_OVF])
    else $error("overflow flag came back without an overflow");

  unf_set_clear_a: assert property (
    (i_stack_underflow && quiet) |=> o_reset_cause_flags[RCF_BIT_UNF]
      ##0 (flags_wr && !i_wdata[RCF_BIT_UNF] && !i_stack_underflow && quiet)
      |=> !o_reset_cause_flags[RCF_BIT_UNF])
    else $error("underflow flag set or clear failed");

  unimpl_zero_a: assert property (
    (i_rd && addr_hit(i_addr, RCF_OFF_FLAGS)) |=> (o_rdata[5:4] == 2'b00)
      && (o_reset_cause_flags[5:4] == 2'b00))
    else $error("unimplemented flag bits read nonzero");

  pin_clear_a: assert property (
    (i_pin_reset && quiet) |=> !o_reset_cause_flags[RCF_BIT_PIN])
    else $error("pin reset flag not cleared");

  soft_clear_a: assert property (
    (i_soft_reset && quiet) |=> !o_reset_cause_flags[RCF_BIT_SOFT])
    else $error("instruction flag not cleared");

  por_rearm_a: assert property (
    (flags_wr && i_wdata[RCF_BIT_POR] && quiet) |=> o_reset_cause_flags[RCF_BIT_POR])
    else $error("power-on flag not re-armed by firmware");

  bor_rearm_a: assert property (
    (flags_wr && i_wdata[RCF_BIT_BOR] && quiet) |=> o_reset_cause_flags[RCF_BIT_BOR])
    else $error("brown-out flag not re-armed by firmware");

  por_pattern_a: assert property (
    i_por_event |=> (o_reset_cause_flags == RCF_POR_VAL))
    else $error("flags wrong after power-on");

  bor_pattern_a: assert property (
    (i_bor_event && !i_por_event) |=>
      ((o_reset_cause_flags & RCF_BOR_LOAD) == RCF_BOR_VAL)
      && (o_reset_cause_flags[RCF_BIT_POR] == $past(o_reset_cause_flags[RCF_BIT_POR])))
    else $error("flags wrong after brown-out");

  stack_req_a: assert property (
    (i_stack_overflow || i_stack_underflow) |=>
      (o_stack_reset_req == $past(i_stack_reset_enable)))
    else $error("stack reset request does not follow the enable");

  no_stray_req_a: assert property (
    (!i_stack_overflow && !i_stack_underflow) |=> !o_stack_reset_req)
    else $error("stack reset request without a stack event");

  hw_wins_a: assert property (
    (flags_wr && i_wdata[RCF_BIT_PIN] && i_pin_reset && quiet)
      |=> !o_reset_cause_flags[RCF_BIT_PIN])
    else $error("firmware write beat a pin reset event");

  read_data_a: assert property (
    (i_rd && addr_hit(i_addr, RCF_OFF_FLAGS)) |=> (o_rdata == $past(o_reset_cause_flags)))
    else $error("flag read data wrong");

  irq_level_a: assert property (
    (irq_evt[RCF_BIT_SOFT] && irq_mask[RCF_BIT_SOFT] && !mask_wr) |=> o_irq)
    else $error("masked-in event did not raise the interrupt");

  // =========================================================
  // scenarios
  por_seen_c:    cover property (i_por_event ##1 flags_wr ##1 o_reset_cause_flags[RCF_BIT_POR]);
  stack_reset_c: cover property (i_stack_overflow && i_stack_reset_enable ##1 o_stack_reset_req);
  race_c:        cover property (flags_wr && i_pin_reset && quiet);
  irq_clear_c:   cover property (o_irq ##1 stat_rd ##1 !o_irq);

endmodule : rcf_reset_cause

// [dv/rcf_testbench.sv]
// self-checking testbench of the reset-cause flag block
`timescale 1ns/1ps
module testbench;
  import rcf_pkg::*;
  // =========================================================
  // stimulus and observation signals
  localparam logic [5:0] EV_OVF  = 6'h20;
  localparam logic [5:0] EV_UNF  = 6'h10;
  localparam logic [5:0] EV_PIN  = 6'h08;
  localparam logic [5:0] EV_SOFT = 6'h04;
  localparam logic [5:0] EV_POR  = 6'h02;
  localparam logic [5:0] EV_BOR  = 6'h01;
  logic                  i_sys_clk = 1'b0;
  logic                  i_sys_rst = 1'b1;
  logic [RCF_ADDR_W-1:0] i_addr = 4'h0;
  logic [RCF_DATA_W-1:0] i_wdata = 8'h00;
  logic                  i_wr = 1'b0;
  logic                  i_rd = 1'b0;
  logic [5:0]            evt = 6'h00;
  logic                  i_stack_reset_enable = 1'b0;
  logic [RCF_DATA_W-1:0] o_rdata;
  logic [RCF_DATA_W-1:0] o_reset_cause_flags;
  logic                  o_stack_reset_req;
  logic                  o_irq;
  logic [RCF_DATA_W-1:0] rd_val;
  int                    n_errors = 0;
  int                    compares = 0;

  // 25 ns period, 40 MHz
  always #12.5 i_sys_clk = ~i_sys_clk;

  // =========================================================
  // device under test
  rcf_reset_cause rcf_reset_cause_i (
    .i_sys_clk            (i_sys_clk),
    .i_sys_rst            (i_sys_rst),
    .i_addr               (i_addr),
    .i_wdata              (i_wdata),
    .i_wr                 (i_wr),
    .i_rd                 (i_rd),
    .o_rdata              (o_rdata),
    .i_stack_overflow     (evt[5]),
    .i_stack_underflow    (evt[4]),
    .i_pin_reset          (evt[3]),
    .i_soft_reset         (evt[2]),
    .i_por_event          (evt[1]),
    .i_bor_event          (evt[0]),
    .i_stack_reset_enable (i_stack_reset_enable),
    .o_reset_cause_flags  (o_reset_cause_flags),
    .o_stack_reset_req    (o_stack_reset_req),
    .o_irq                (o_irq)
  );

  // =========================================================
  // shared tasks
  task automatic results;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one-cycle write; the strobe drops on the next edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1;
    rd_val = o_rdata;
  endtask : rd

  // event pulse, optionally beside a flag write in the same cycle
  task automatic ev(input logic [5:0] e, input logic w, input logic [7:0] d);
    @(posedge i_sys_clk);
    evt <= e;
    i_wr <= w;
    i_addr <= RCF_OFF_FLAGS;
    i_wdata <= d;
    @(posedge i_sys_clk);
    evt <= 6'h00;
    i_wr <= 1'b0;
    #1;
  endtask : ev

  // =========================================================
  // scenarios
  task automatic t_reset;
    rd(RCF_OFF_FLAGS);
    chk(rd_val, 8'h0c);
    rd(RCF_OFF_IRQ_STAT);
    chk(rd_val, 8'h00);
    rd(RCF_OFF_IRQ_MASK);
    chk(rd_val, 8'h00);
    chk({7'h00, o_irq}, 8'h00);
  endtask : t_reset

  // absent bits and an unmapped place ignore writes
  task automatic t_regs;
    wr(RCF_OFF_FLAGS, 8'hff);
    rd(RCF_OFF_FLAGS);
    chk(rd_val, 8'hcf);
    wr(RCF_OFF_FLAGS, 8'h00);
    rd(RCF_OFF_FLAGS);
    chk(rd_val, 8'h00);
    wr(RCF_OFF_FLAGS, 8'h0f);
    wr(4'h5, 8'hff);
    rd(4'h5);
    chk(rd_val, 8'h00);
    rd(RCF_OFF_FLAGS);
    chk(rd_val, 8'h0f);
  endtask : t_regs

  // stack flags with and without the reset enable
  task automatic t_stack;
    i_stack_reset_enable <= 1'b1;
    ev(EV_OVF, 1'b0, 8'h00);
    chk(o_reset_cause_flags, 8'h8f);
    chk({7'h00, o_stack_reset_req}, 8'h01);
    @(posedge i_sys_clk);
    #1;
    chk({7'h00, o_stack_reset_req}, 8'h00);
    wr(RCF_OFF_FLAGS, 8'h0f);
    repeat (3) @(posedge i_sys_clk);
    chk(o_reset_cause_flags, 8'h0f);
    i_stack_reset_enable <= 1'b0;
    ev(EV_UNF, 1'b0, 8'h00);
    chk(o_reset_cause_flags, 8'h4f);
    chk({7'h00, o_stack_reset_req}, 8'h00);
    wr(RCF_OFF_FLAGS, 8'h0f);
    #1;
    chk(o_reset_cause_flags, 8'h0f);
  endtask : t_stack

  // active-low pin and instruction flags, then re-arm
  task automatic t_low;
    ev(EV_PIN, 1'b0, 8'h00);
    chk(o_reset_cause_flags, 8'h07);
    ev(EV_SOFT, 1'b0, 8'h00);
    chk(o_reset_cause_flags, 8'h03);
    wr(RCF_OFF_FLAGS, 8'h0f);
    #1;
    chk(o_reset_cause_flags, 8'h0f);
  endtask : t_low

  // power-on and brown-out load patterns
  task automatic t_power;
    ev(EV_OVF | EV_UNF, 1'b0, 8'h00);
    ev(EV_POR, 1'b0, 8'h00);
    chk(o_reset_cause_flags, 8'h0c);
    wr(RCF_OFF_FLAGS, 8'hcf); // firmware re-arms power-on flag
    ev(EV_BOR, 1'b0, 8'h00);
    chk(o_reset_cause_flags, 8'h0e);
    wr(RCF_OFF_FLAGS, 8'h0d);
    ev(EV_BOR, 1'b0, 8'h00);
    chk(o_reset_cause_flags, 8'h0c);
    wr(RCF_OFF_FLAGS, 8'h0f); // firmware re-arms brown-out flag
  endtask : t_power

  // hardware event beats a firmware write in the same cycle
  task automatic t_prio;
    ev(EV_OVF, 1'b1, 8'h00);
    chk(o_reset_cause_flags, 8'h80);
    ev(EV_PIN, 1'b1, 8'h0f);
    chk(o_reset_cause_flags, 8'h07);
    wr(RCF_OFF_FLAGS, 8'h0f);
  endtask : t_prio

  // sticky status, mask and level interrupt
  task automatic t_irq;
    rd(RCF_OFF_IRQ_STAT);
    wr(RCF_OFF_IRQ_MASK, 8'hff);
    rd(RCF_OFF_IRQ_MASK);
    chk(rd_val, 8'hcf);
    ev(EV_OVF, 1'b0, 8'h00);
    chk({7'h00, o_irq}, 8'h01);
    rd(RCF_OFF_IRQ_STAT);
    chk(rd_val, 8'h80);
    @(posedge i_sys_clk);
    #1;
    chk({7'h00, o_irq}, 8'h00);
    wr(RCF_OFF_IRQ_MASK, 8'h00);
    ev(EV_UNF, 1'b0, 8'h00);
    repeat (2) @(posedge i_sys_clk);
    chk({7'h00, o_irq}, 8'h00);
    rd(RCF_OFF_IRQ_STAT);
    chk(rd_val, 8'h40);
  endtask : t_irq

  // =========================================================
  // main sequence and hang guard
  initial begin
    repeat (2) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    t_reset();
    t_regs();
    t_stack();
    t_low();
    t_power();
    t_prio();
    t_irq();
    results();
  end

  initial begin
    repeat (5000) @(posedge i_sys_clk);
    n_errors++;
    results();
  end
endmodule : testbench
